/* File: snoop_consts.vh */
`ifndef SNOOP_CONSTS_VH
`define SNOOP_CONSTS_VH
// address field widths
`define SNP_TAG_W 12
`define SNP_SET_W 13
`define SNP_CFG_W 1
`define SNP_ADDR_W 26
// synchronised pin bundle: mode pin, strobe, inv, nca, bus aoe, aoe, parity, address
`define SNP_SYNC_W 33
`define SNP_SYNC_MODE 32
`define SNP_SYNC_STB 31
`define SNP_SYNC_INV 30
`define SNP_SYNC_NCA 29
`define SNP_SYNC_BAOE 28
`define SNP_SYNC_AOE 27
`define SNP_SYNC_PAR 26
// line states
`define LINE_I 2'h0
`define LINE_S 2'h1
`define LINE_E 2'h2
`define LINE_M 2'h3
// initiation modes
`define MODE_SYNC 2'h0
`define MODE_CLOCKED 2'h1
`define MODE_STROBED 2'h2
// least clocks from busy release to the next look-up, and its load value
`define SNP_BUSY_GAP 2
`define SNP_HOLDOFF_LOAD 2'h1
`endif

/* File: snoop_sync2.v */
`timescale 1ns/10ps
`default_nettype none
module snoop_sync2 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // data
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] meta_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= INIT;
      dout <= INIT;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* File: snoop_request_port.v */
`include "snoop_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module snoop_request_port (
  // clock and reset
  input wire clk,
  input wire rst,
  // snoop request pins
  input wire snoop_mode_pin,
  input wire snoop_request_strobe_n,
  input wire snoop_invalidate_attr,
  input wire snoop_noncaching_attr,
  input wire bus_address_output_enable_n,
  input wire address_output_enable_n,
  input wire [`SNP_CFG_W-1:0] snoop_addr_config,
  input wire [`SNP_SET_W-1:0] snoop_addr_set_index,
  input wire [`SNP_TAG_W-1:0] snoop_addr_tag,
  input wire snoop_addr_parity,
  // own memory bus cycle progress
  input wire bus_grant_n,
  input wire snoop_window_end_n,
  input wire writeback_done_n,
  // tag array
  input wire [1:0] tag_line_state,
  output reg [`SNP_ADDR_W-1:0] lookup_addr,
  output reg tag_write,
  output reg [1:0] tag_write_state,
  // snoop responses
  output reg snoop_lookup_cycle_n,
  output reg snoop_tag_hit_n,
  output reg snoop_hit_modified_n,
  output reg snoop_busy_n,
  output reg address_parity_error_n,
  output reg writeback_request,
  output reg lookup_bus_aoe_n,
  output reg own_cycle_active,
  output reg [1:0] snoop_mode
);
  // =====================================================
  // pin synchronisation
  wire [`SNP_SYNC_W-1:0] pins_raw;
  wire [`SNP_SYNC_W-1:0] pins_s;
  assign pins_raw = {snoop_mode_pin, snoop_request_strobe_n, snoop_invalidate_attr,
                     snoop_noncaching_attr, bus_address_output_enable_n,
                     address_output_enable_n, snoop_addr_parity, snoop_addr_config,
                     snoop_addr_set_index, snoop_addr_tag};

  // strobe, enables and the pulled-up mode pin idle high, so a reset release
  // fakes neither a request nor a snoop clock edge
  snoop_sync2 #(
    .W(`SNP_SYNC_W),
    .INIT(33'h1_9800_0000)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .din(pins_raw),
    .dout(pins_s)
  );

  // =====================================================
  // mode selection
  reg mode_taken_reg;
  reg mode_prev_reg;
  reg stb_prev_reg;
  reg strap_meta_reg;
  reg strap_reg;
  wire snoop_sample_clock_rise;
  assign snoop_sample_clock_rise = pins_s[`SNP_SYNC_MODE] & ~mode_prev_reg;

  // no reset here, so the strap keeps tracking the pin while reset is held;
  // reset must therefore span at least two clocks for the strap to settle
  always @(posedge clk) begin
    strap_meta_reg <= snoop_mode_pin;
    strap_reg <= strap_meta_reg;
  end

  // strap used at the first edge after release; a later clock edge switches to clocked
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_taken_reg <= 1'b0;
      mode_prev_reg <= 1'b1;
      stb_prev_reg <= 1'b1;
      snoop_mode <= `MODE_SYNC;
    end else begin
      mode_prev_reg <= pins_s[`SNP_SYNC_MODE];
      stb_prev_reg <= pins_s[`SNP_SYNC_STB];
      if (!mode_taken_reg) begin
        mode_taken_reg <= 1'b1;
        snoop_mode <= strap_reg ? `MODE_STROBED : `MODE_SYNC;
      end else if (snoop_sample_clock_rise && mode_prev_reg == 1'b0 && snoop_mode != `MODE_CLOCKED &&
                   mode_taken_reg) begin
        snoop_mode <= `MODE_CLOCKED;
      end
    end
  end

  // =====================================================
  // request recognition
  reg armed_reg;
  reg sample_now;
  reg strobe_act;
  reg [`SNP_SYNC_W-2:0] smp;

  // in synchronous mode the pins already belong to clk, so no synchroniser delay
  always @* begin
    smp = pins_s[`SNP_SYNC_W-2:0];
    sample_now = 1'b0;
    strobe_act = 1'b0;
    case (snoop_mode)
      `MODE_SYNC: begin
        smp = pins_raw[`SNP_SYNC_W-2:0];
        sample_now = 1'b1;
        strobe_act = ~snoop_request_strobe_n;
      end
      `MODE_CLOCKED: begin
        sample_now = snoop_sample_clock_rise;
        strobe_act = ~pins_s[`SNP_SYNC_STB];
      end
      default: begin
        sample_now = 1'b1;
        strobe_act = stb_prev_reg & ~pins_s[`SNP_SYNC_STB];
      end
    endcase
  end

  wire new_req;
  assign new_req = mode_taken_reg & sample_now & strobe_act & armed_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b1;
    end else if (sample_now && mode_taken_reg) begin
      if (snoop_mode == `MODE_STROBED) begin
        armed_reg <= 1'b1;
      end else begin
        armed_reg <= ~strobe_act;
      end
    end
  end

  // =====================================================
  // pending request and look-up scheduling
  reg req_valid_reg;
  reg req_inv_reg;
  reg req_nca_reg;
  reg req_baoe_reg;
  reg req_par_err_reg;
  reg [`SNP_ADDR_W-1:0] req_addr_reg;
  reg [1:0] holdoff_reg;
  reg lookup_inv_reg;
  reg lookup_nca_reg;
  reg lookup_perr_reg;
  wire lookup_next;
  wire lookup_now;
  wire take_req;
  assign lookup_now = ~snoop_lookup_cycle_n;
  // only one request waits; a further one before the look-up is lost by the controller's fault
  assign take_req = new_req & smp[`SNP_SYNC_AOE] & (~req_valid_reg | lookup_next);
  assign lookup_next = req_valid_reg & snoop_busy_n & (holdoff_reg == 2'h0) &
                       ~own_cycle_active & ~lookup_now;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      req_valid_reg <= 1'b0;
      req_inv_reg <= 1'b0;
      req_nca_reg <= 1'b0;
      req_baoe_reg <= 1'b1;
      req_par_err_reg <= 1'b0;
      req_addr_reg <= {`SNP_ADDR_W{1'b0}};
    end else if (take_req) begin
      req_valid_reg <= 1'b1;
      req_inv_reg <= smp[`SNP_SYNC_INV];
      req_nca_reg <= smp[`SNP_SYNC_NCA];
      req_baoe_reg <= smp[`SNP_SYNC_BAOE];
      // even parity over address and parity bit
      req_par_err_reg <= ^smp[`SNP_SYNC_PAR:0];
      req_addr_reg <= smp[`SNP_ADDR_W-1:0];
    end else if (lookup_next) begin
      req_valid_reg <= 1'b0;
    end
  end

  // =====================================================
  // look-up cycle, results and busy
  reg [1:0] new_state;
  reg hit;
  reg hit_m;
  always @* begin
    hit = (tag_line_state != `LINE_I);
    hit_m = (tag_line_state == `LINE_M);
    new_state = tag_line_state;
    if (lookup_inv_reg) begin
      new_state = `LINE_I;
    end else if (lookup_nca_reg) begin
      if (hit_m) begin
        new_state = `LINE_E;
      end
    end else if (hit) begin
      new_state = `LINE_S;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      snoop_lookup_cycle_n <= 1'b1;
      lookup_addr <= {`SNP_ADDR_W{1'b0}};
      lookup_bus_aoe_n <= 1'b1;
      lookup_inv_reg <= 1'b0;
      lookup_nca_reg <= 1'b0;
      lookup_perr_reg <= 1'b0;
      snoop_tag_hit_n <= 1'b1;
      snoop_hit_modified_n <= 1'b1;
      address_parity_error_n <= 1'b1;
      snoop_busy_n <= 1'b1;
      writeback_request <= 1'b0;
      tag_write <= 1'b0;
      tag_write_state <= `LINE_I;
      holdoff_reg <= 2'h0;
    end else begin
      snoop_lookup_cycle_n <= ~lookup_next;
      if (lookup_next) begin
        lookup_addr <= req_addr_reg;
        lookup_bus_aoe_n <= req_baoe_reg;
        lookup_inv_reg <= req_inv_reg;
        lookup_nca_reg <= req_nca_reg;
        lookup_perr_reg <= req_par_err_reg & (snoop_mode != `MODE_SYNC);
      end
      tag_write <= lookup_now;
      tag_write_state <= new_state;
      writeback_request <= lookup_now & hit_m;
      if (lookup_now) begin
        snoop_tag_hit_n <= ~hit;
        address_parity_error_n <= ~lookup_perr_reg;
      end
      if (lookup_now && hit_m) begin
        snoop_busy_n <= 1'b0;
        snoop_hit_modified_n <= 1'b0;
      end else if (!snoop_busy_n && !writeback_done_n) begin
        snoop_busy_n <= 1'b1;
        snoop_hit_modified_n <= 1'b1;
        holdoff_reg <= `SNP_HOLDOFF_LOAD;
      end else if (holdoff_reg != 2'h0) begin
        holdoff_reg <= holdoff_reg - 2'h1;
      end
    end
  end

  // =====================================================
  // own memory bus cycle window
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      own_cycle_active <= 1'b0;
    end else if (!bus_grant_n && !lookup_now) begin
      // a grant in the window-end clock starts the next cycle, so the set wins; a grant during a look-up clock is ignored
      own_cycle_active <= 1'b1;
    end else if (!snoop_window_end_n) begin
      own_cycle_active <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: snoop_port_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "snoop_consts.vh"
// ==========================================
// snoop response checker
module snoop_port_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // observed ports
  input wire logic [1:0] tag_line_state,
  input wire logic snoop_lookup_cycle_n,
  input wire logic snoop_tag_hit_n,
  input wire logic snoop_hit_modified_n,
  input wire logic snoop_busy_n,
  input wire logic address_parity_error_n,
  input wire logic writeback_request,
  input wire logic own_cycle_active,
  input wire logic [1:0] snoop_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_lookup;
    $fell(snoop_lookup_cycle_n);
  endsequence
  sequence s_quiet2;
    snoop_lookup_cycle_n[*2];
  endsequence
  a_lookup_one_clk: assert property (s_lookup |=> snoop_lookup_cycle_n)
    else $error("look-up held beyond one clock");
  a_hit_result: assert property (!snoop_lookup_cycle_n |=>
    snoop_tag_hit_n == ($past(tag_line_state) == `LINE_I)) else $error("bad tag hit");
  a_modified_wb: assert property (!snoop_lookup_cycle_n && tag_line_state == `LINE_M |=>
    writeback_request && !snoop_busy_n && !snoop_hit_modified_n) else $error("no writeback");
  a_busy_blocks: assert property (!snoop_busy_n |-> snoop_lookup_cycle_n)
    else $error("look-up while busy");
  a_busy_gap: assert property ($rose(snoop_busy_n) |-> s_quiet2)
    else $error("look-up too soon after busy");
  a_own_blocks: assert property (own_cycle_active[*2] |-> snoop_lookup_cycle_n)
    else $error("look-up during own bus cycle");
  a_sync_no_perr: assert property (snoop_mode == `MODE_SYNC |-> address_parity_error_n)
    else $error("parity error in synchronous mode");
  a_perr_lookup: assert property ($fell(address_parity_error_n) |->
    $past(snoop_lookup_cycle_n) == 1'b0) else $error("parity error away from a look-up");
  a_mode_fixed: assert property (snoop_mode != `MODE_SYNC |=> $stable(snoop_mode))
    else $error("mode changed");
endmodule
bind snoop_request_port snoop_port_monitor i_snoop_port_monitor (
  .clk(clk), .rst(rst), .tag_line_state(tag_line_state),
  .snoop_lookup_cycle_n(snoop_lookup_cycle_n), .snoop_tag_hit_n(snoop_tag_hit_n),
  .snoop_hit_modified_n(snoop_hit_modified_n), .snoop_busy_n(snoop_busy_n),
  .address_parity_error_n(address_parity_error_n), .writeback_request(writeback_request),
  .own_cycle_active(own_cycle_active), .snoop_mode(snoop_mode));
`default_nettype wire

/* File: snoop_bus_master.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// memory bus controller issuing snoops
module snoop_bus_master (
  // clock
  input wire logic clk,
  // snoop request pins
  output var logic strobe_n,
  output var logic inv,
  output var logic nca,
  output var logic baoe_n,
  output var logic aoe_n,
  output var logic [25:0] addr,
  output var logic par
);
  initial begin
    strobe_n = 1'b1;
    {inv, nca, baoe_n, aoe_n, addr, par} = '1;
  end
  task automatic issue(input logic i, input logic n, input logic [25:0] a, input logic bad,
                       input int hold);
    @(posedge clk);
    strobe_n <= 1'b0;
    inv <= i;
    nca <= n;
    addr <= a;
    baoe_n <= a[0];
    par <= ^a ^ bad;
    // in clocked mode the request must straddle one snoop clock rise
    repeat (hold) @(posedge clk);
    strobe_n <= 1'b1;
    // attributes are don't-care once the strobe is gone, so scramble them
    inv <= ~i;
    nca <= ~n;
    addr <= ~a;
  endtask
endmodule
`default_nettype wire

/* File: snoop_request_port_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "snoop_consts.vh"
module snoop_request_port_test;
  logic clk, rst, mode_pin, strap, lclk_on, grant_n, wend_n, wbdone_n;
  logic [1:0] cur_state;
  wire logic stb_n, inv, nca, baoe_n, aoe_n, par, tw, lk_n, hit_n, hitm_n, busy_n, perr_n;
  wire logic wbreq, lbaoe_n, own;
  wire logic [25:0] a, lk_addr;
  wire logic [1:0] tws, mode;
  int error_cnt, n_compared, qe[$];
  logic [25:0] qa[$];
  snoop_request_port i_snoop_request_port (.clk(clk), .rst(rst), .snoop_mode_pin(mode_pin),
    .snoop_request_strobe_n(stb_n), .snoop_invalidate_attr(inv), .snoop_noncaching_attr(nca),
    .bus_address_output_enable_n(baoe_n), .address_output_enable_n(aoe_n),
    .snoop_addr_config(a[25]), .snoop_addr_set_index(a[24:12]), .snoop_addr_tag(a[11:0]),
    .snoop_addr_parity(par), .bus_grant_n(grant_n), .snoop_window_end_n(wend_n),
    .writeback_done_n(wbdone_n), .tag_line_state(cur_state), .lookup_addr(lk_addr),
    .tag_write(tw), .tag_write_state(tws), .snoop_lookup_cycle_n(lk_n),
    .snoop_tag_hit_n(hit_n), .snoop_hit_modified_n(hitm_n), .snoop_busy_n(busy_n),
    .address_parity_error_n(perr_n), .writeback_request(wbreq), .lookup_bus_aoe_n(lbaoe_n),
    .own_cycle_active(own), .snoop_mode(mode));
  snoop_bus_master i_snoop_bus_master (.clk(clk), .strobe_n(stb_n), .inv(inv), .nca(nca),
    .baoe_n(baoe_n), .aoe_n(aoe_n), .addr(a), .par(par));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // snoop clock off the main clock's phase
  always @* if (!lclk_on) mode_pin = strap;
  initial begin
    #7;
    forever #100 if (lclk_on) mode_pin = ~mode_pin;
  end
  task check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic int next_state(int st, int i, int n);
    if (st == 0 || i) return 0;
    if (n) return (st == 3) ? 2 : st;
    return 1;
  endfunction
  task send(input int st, input int i, input int n, input int bad);
    logic [25:0] ad;
    ad = $urandom;
    qa.push_back(ad);
    qe.push_back(st * 8 + i * 4 + n * 2 + bad);
    @(posedge clk) cur_state <= st[1:0];
    // a clocked controller launches its strobe just after a snoop clock rise
    if (lclk_on) @(posedge mode_pin);
    i_snoop_bus_master.issue(i[0], n[0], ad, bad[0], lclk_on ? 8 : 1);
  endtask
  task check();
    int e, k;
    logic [25:0] ad;
    ad = qa.pop_front();
    e = qe.pop_front();
    #1;
    for (k = 0; k < 40 && lk_n !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    check_val(lk_n, 0);
    check_val(lk_addr, ad);
    @(posedge clk);
    #1;
    check_val(lk_n, 1);
    check_val(hit_n, e / 8 == 0);
    check_val(hitm_n, e / 8 != 3);
    check_val(busy_n, e / 8 != 3);
    check_val(wbreq, e / 8 == 3);
    check_val(lbaoe_n, ad[0]);
    check_val(perr_n, !(e % 2 && mode != `MODE_SYNC));
    check_val(tw, 1);
    check_val(tws, next_state(e / 8, e / 4 % 2, e / 2 % 2));
  endtask
  task release_busy();
    @(posedge clk) wbdone_n <= 1'b0;
    @(posedge clk) wbdone_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check_val(busy_n, 1);
  endtask
  task do_reset(input logic s);
    // the strap is set with reset so that it has settled before the release
    @(posedge clk);
    rst <= 1'b1;
    strap <= s;
    lclk_on <= 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task finish_test();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    finish_test();
  end
  initial begin
    int k;
    {rst, strap, lclk_on, grant_n, wend_n, wbdone_n, cur_state} = 8'h9c;
    error_cnt = 0;
    n_compared = 0;
    void'($urandom(32'h6c35715e));
    do_reset(0);
    check_val(mode, `MODE_SYNC);
    for (k = 0; k < 16; k++) begin
      send(k / 4, k / 2 % 2, k % 2, k % 2);
      check();
      if (k / 4 == 3) release_busy();
    end
    // second request held pending while busy
    send(3, 1, 0, 0);
    check();
    send(1, 0, 0, 0);
    repeat (3) @(posedge clk);
    #1 check_val(lk_n, 1);
    release_busy();
    check();
    // request during own memory bus cycle; the grant comes well after the last look-up,
    // so a read-miss burst ready would keep its least spacing from that look-up
    repeat (6) @(posedge clk);
    @(posedge clk) grant_n <= 1'b0;
    @(posedge clk) grant_n <= 1'b1;
    send(2, 0, 1, 0);
    repeat (4) @(posedge clk);
    #1 check_val({own, lk_n}, 2'h3);
    @(posedge clk) wend_n <= 1'b0;
    @(posedge clk) wend_n <= 1'b1;
    check();
    do_reset(1);
    check_val(mode, `MODE_STROBED);
    send(2, 0, 0, 1);
    check();
    send(1, 1, 0, 0);
    check();
    do_reset(0);
    @(posedge clk) lclk_on <= 1'b1;
    repeat (40) @(posedge clk);
    #1 check_val(mode, `MODE_CLOCKED);
    send(2, 1, 1, 1);
    check();
    send(1, 0, 1, 0);
    check();
    finish_test();
  end
endmodule
`default_nettype wire
